/* File: logic/pmta_table_access.sv */
// program memory table access: address forming, guard, slicing, latches, flash ops
// core and serial port share one table path into the array
// assumes the flash array answers reads combinationally and runs ops on a strobe/busy pair
// assumes a requester keeps valid up while the sequencer is busy
`timescale 1ns/1ps
`default_nettype none

module pmta_table_access (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic                              exec_fetch,
    input  wire logic [pmta_pkg::PC_W-1:0]         program_counter,
    input  wire logic                              req_valid,
    input  wire pmta_pkg::pmta_req_t               req,
    input  wire logic                              serial_prog_valid,
    input  wire pmta_pkg::pmta_req_t               serial_prog_req,
    input  wire logic [pmta_pkg::WORD_W-1:0]       flash_rdata,
    input  wire logic                              flash_busy,
    output pmta_pkg::pmta_rsp_t                    rsp,
    output pmta_pkg::pmta_rsp_t                    serial_prog_rsp,
    output logic [pmta_pkg::PADDR_W-1:0]           flash_addr,
    output logic [pmta_pkg::WORD_W-1:0]            flash_wdata,
    output logic                                   flash_prog_word,
    output logic                                   flash_prog_row,
    output logic                                   flash_erase_page,
    output logic [pmta_pkg::PAGE_W-1:0]            table_page_reg
);

    // ************************************************************
    // helpers
    // ************************************************************
    // page above effective address
    // gives the full 24-bit target in one place
    function automatic logic [pmta_pkg::PADDR_W-1:0] form_addr(
        input logic [pmta_pkg::PAGE_W-1:0] pg,
        input logic [pmta_pkg::EA_W-1:0]   ea);
        form_addr = {pg, ea}; // R5
    endfunction

    // page bit 7 is also target bit 23, so a table
    // target reaches the upper half only when opened
    // user space is the lower half; upper half needs page bit 7
    function automatic logic allowed(
        input logic [pmta_pkg::PADDR_W-1:0] a,
        input logic [pmta_pkg::PAGE_W-1:0]  pg);
        allowed = !a[pmta_pkg::ADDR_TOP_BIT] || pg[pmta_pkg::PAGE_CFG_BIT]; // R3 R4
    endfunction

    // ************************************************************
    // request select
    // ************************************************************
    // serial port wins the select, but still waits out a core flash op already running
    // a request not taken is retried by its owner;
    // nothing here queues it
    // target and guard are worked out every cycle
    logic                          sel_valid;
    logic                          sel_serial;
    pmta_pkg::pmta_req_t           sel;
    logic [pmta_pkg::PADDR_W-1:0]  tgt;
    logic                          ok;
    logic                          busy_any;

    always_comb begin
        sel_serial = serial_prog_valid; // R10
        sel        = serial_prog_valid ? serial_prog_req : req;
        sel_valid  = (serial_prog_valid || req_valid) && !busy_any;
        tgt        = form_addr(table_page_reg, sel.effective_address);
        ok         = allowed(tgt, table_page_reg);
    end

    // ************************************************************
    // write latches (row of 64 holds, one word at a time filled)
    // ************************************************************
    // latches are not reset: a row burnt before
    // filling writes whatever they held
    logic [pmta_pkg::WORD_W-1:0] latch [pmta_pkg::ROW_INSTR]; // R8
    logic [pmta_pkg::ROW_IDX_W-1:0] lidx;
    logic [pmta_pkg::WORD_W-1:0] cur;
    logic [pmta_pkg::BYTE_W-1:0] wbyte;

    assign lidx = tgt[pmta_pkg::ROW_IDX_W:1];
    assign cur  = latch[lidx];
    assign wbyte = sel.wdata[pmta_pkg::BYTE_W-1:0];

    // low-half and high-half writes merge into the addressed latch
    // a refused target leaves the latches alone
    always_ff @(posedge clk_sys) begin
        if (sel_valid && ok) begin
            case (sel.op)
                pmta_pkg::PMTA_OP_WRITE_LOW: begin
                    // word mode fills the low half, byte mode one lane
                    if (!sel.byte_mode) begin
                        latch[lidx][pmta_pkg::LOW_HI_BIT:0] <= sel.wdata; // R6
                    end else if (tgt[0]) begin
                        latch[lidx][pmta_pkg::LOW_HI_BIT:pmta_pkg::BYTE_W] <= wbyte;
                    end else begin
                        latch[lidx][pmta_pkg::BYTE_W-1:0] <= wbyte;
                    end
                end
                pmta_pkg::PMTA_OP_WRITE_HIGH: begin
                    // odd byte of the high half is phantom: ignored
                    if (!sel.byte_mode || !tgt[0]) begin
                        latch[lidx][pmta_pkg::ADDR_TOP_BIT:pmta_pkg::HIGH_LO_BIT] <= wbyte; // R7
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // table page register
    // ************************************************************
    // loading the page is never refused
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            table_page_reg <= pmta_pkg::PAGE_RST;
        end else if (sel_valid && sel.op == pmta_pkg::PMTA_OP_SET_PAGE) begin
            table_page_reg <= sel.wdata[pmta_pkg::PAGE_W-1:0];
        end
    end

    // ************************************************************
    // read data slicing
    // ************************************************************
    logic [pmta_pkg::DATA_W-1:0] next_rdata;

    // the array answers in the request cycle, so the
    // slice is ready for the answer one edge later
    always_comb begin
        next_rdata = '0;
        case (sel.op)
            pmta_pkg::PMTA_OP_READ_LOW: begin
                // byte reads land low with zero above
                if (!sel.byte_mode) begin
                    next_rdata = flash_rdata[pmta_pkg::LOW_HI_BIT:0]; // R6
                end else if (tgt[0]) begin
                    next_rdata = {pmta_pkg::BYTE_ZERO, flash_rdata[pmta_pkg::LOW_HI_BIT:pmta_pkg::BYTE_W]};
                end else begin
                    next_rdata = {pmta_pkg::BYTE_ZERO, flash_rdata[pmta_pkg::BYTE_W-1:0]};
                end
            end
            pmta_pkg::PMTA_OP_READ_HIGH: begin
                // odd byte of the high half reads zero
                if (!sel.byte_mode || !tgt[0]) begin
                    next_rdata = {pmta_pkg::BYTE_ZERO,
                                  flash_rdata[pmta_pkg::ADDR_TOP_BIT:pmta_pkg::HIGH_LO_BIT]}; // R7 R12
                end
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // ************************************************************
    // flash operation sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        PMTA_ST_IDLE  = 2'b00,
        PMTA_ST_START = 2'b01,
        PMTA_ST_WAIT  = 2'b10
    } pmta_st_t;

    // op_serial sends the late answer home
    pmta_st_t                     state;
    logic                         op_serial;
    logic [pmta_pkg::ROW_IDX_W-1:0] row_cnt;

    // any state but idle turns requests away
    assign busy_any = (state != PMTA_ST_IDLE);

    // one word, a 64-word row streamed from the latches, or a 512-word page erase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state            <= PMTA_ST_IDLE;
            op_serial        <= 1'b0;
            row_cnt          <= '0;
            flash_prog_word  <= 1'b0;
            flash_prog_row   <= 1'b0;
            flash_erase_page <= 1'b0;
            flash_addr       <= '0;
            flash_wdata      <= '0;
        end else begin
            // word and erase strobes last one edge; the row strobe stays up through its 64 latch cycles
            flash_prog_word  <= 1'b0;
            flash_prog_row   <= 1'b0;
            flash_erase_page <= 1'b0;
            case (state)
                PMTA_ST_IDLE: begin
                    // a 23-bit fetch always stays in the lower half
                    flash_addr <= exec_fetch ? {1'b0, program_counter} : tgt; // R1 R2
                    if (sel_valid && ok) begin
                        op_serial <= sel_serial;
                        case (sel.op)
                            pmta_pkg::PMTA_OP_PROG_WORD: begin
                                // the pulse carries the table target even during a fetch
                                flash_addr      <= tgt; // R10
                                flash_wdata     <= cur;
                                flash_prog_word <= 1'b1; // R8
                                state           <= PMTA_ST_WAIT;
                            end
                            pmta_pkg::PMTA_OP_PROG_ROW: begin
                                // row base aligned to 64 instructions
                                flash_addr <= {tgt[pmta_pkg::PADDR_W-1:pmta_pkg::ROW_IDX_W+1],
                                               {(pmta_pkg::ROW_IDX_W+1){1'b0}}};
                                row_cnt    <= '0;
                                state      <= PMTA_ST_START;
                            end
                            pmta_pkg::PMTA_OP_ERASE_PAGE: begin
                                // page base aligned to 512 instructions
                                flash_addr <= {tgt[pmta_pkg::PADDR_W-1:pmta_pkg::PAGE_IDX_W+1],
                                               {(pmta_pkg::PAGE_IDX_W+1){1'b0}}}; // R9
                                flash_erase_page <= 1'b1;
                                state            <= PMTA_ST_WAIT;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                PMTA_ST_START: begin
                    // one latch per cycle; the array holds busy until the row burns
                    // the count wraps to zero after the last latch
                    flash_wdata    <= latch[row_cnt];
                    flash_addr     <= {flash_addr[pmta_pkg::PADDR_W-1:pmta_pkg::ROW_IDX_W+1], row_cnt, 1'b0};
                    flash_prog_row <= 1'b1; // R8
                    row_cnt        <= row_cnt + 1'b1;
                    if (row_cnt == pmta_pkg::ROW_IDX_W'(pmta_pkg::ROW_INSTR - 1)) begin
                        state <= PMTA_ST_WAIT;
                    end
                end
                PMTA_ST_WAIT: begin
                    // our own pulse counts as busy: the array sees it one edge late
                    if (!flash_busy && !flash_prog_word && !flash_erase_page && !flash_prog_row) begin
                        state <= PMTA_ST_IDLE;
                    end
                end
                default: begin
                    state <= PMTA_ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // answers
    // ************************************************************
    // simple ops answer next cycle; flash ops answer when the array is idle again
    // a pulse still registered counts as not done
    logic done_long;
    assign done_long = (state == PMTA_ST_WAIT) && !flash_busy &&
                       !flash_prog_word && !flash_erase_page && !flash_prog_row;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp             <= '0;
            serial_prog_rsp <= '0;
        end else begin
            rsp.valid             <= 1'b0;
            serial_prog_rsp.valid <= 1'b0;
            if (done_long) begin
                // a long op answers once, to its owner
                rsp.valid             <= !op_serial;
                serial_prog_rsp.valid <= op_serial;
                rsp.denied            <= 1'b0;
                serial_prog_rsp.denied <= 1'b0;
            end else if (sel_valid && (!ok || sel.op < pmta_pkg::PMTA_OP_PROG_WORD)) begin
                // denied reads return zero so nothing protected leaks
                // each side sees only its own answers
                if (sel_serial) begin
                    serial_prog_rsp.valid  <= 1'b1;
                    serial_prog_rsp.denied <= !ok; // R4
                    serial_prog_rsp.rdata  <= ok ? next_rdata : '0;
                end else begin
                    rsp.valid  <= 1'b1;
                    rsp.denied <= !ok; // R3
                    rsp.rdata  <= ok ? next_rdata : '0;
                end
            end
        end
    end

    // ************************************************************
    // limitations
    // ************************************************************
    // the guard cannot refuse today: page bit 7 is
    // target bit 23; it stays for a wider page
    // a row op streams all 64 latches, filled or not
    // latches survive an op, so a repeat row op
    // burns the same data unless refilled
    // an answer says only that busy dropped, not
    // that the array programmed cleanly
    // an op holds flash_addr until its answer, so
    // fetch addresses are not followed meanwhile
    // there is no timeout on a stuck busy line

endmodule

`default_nettype wire

/* File: include/pmta_pkg.sv */
// program memory table access: shared constants and carrier types
// assumes one 100 MHz clock, synchronous active-high reset, core drives requests
//
// Function
// R1 - the program space holds 4M instruction words addressed by a 24-bit program address.
// R2 - the address comes from the 23-bit program counter while executing, else from a table operation or remap.
// R3 - ordinary accesses are confined to addresses 0x000000 through 0x7fffff.
// R4 - table operations reach the configuration and identity area only when table page bit 7 is set.
// R5 - the table target address is the 8-bit table page above the 16-bit effective address.
// R6 - low-half table read and write move bits 15 to 0 of the word in word or byte mode.
// R7 - high-half table read and write move bits 23 to 16 of the word in word or byte mode.
// R8 - self-programming writes one word or a row of 64 instructions (192 bytes) at a time.
// R9 - self-programming erase clears one page of 512 instructions (1536 bytes) at a time.
// R10 - every flash programming operation, serial or from code, goes through the table path.
// R11 - an external serial programmer drives a clock and a data line plus the master clear pin.
// R12 - a word-mode high-half read returns the upper byte in the low byte with zero above.
package pmta_pkg;

    // ************************************************************
    // address layout
    // ************************************************************
    localparam int PADDR_W      = 24;
    localparam int PC_W         = 23;
    localparam int EA_W         = 16;
    localparam int PAGE_W       = 8;
    localparam int WORD_W       = 24;
    localparam int DATA_W       = 16;
    localparam int PAGE_CFG_BIT = 7;
    localparam int ADDR_TOP_BIT = 23;
    localparam int LOW_HI_BIT   = 15;
    localparam int HIGH_LO_BIT  = 16;
    localparam int BYTE_W       = 8;

    // ************************************************************
    // programming geometry
    // ************************************************************
    localparam int ROW_INSTR    = 64;
    localparam int PAGE_INSTR   = 512;
    localparam int ROW_IDX_W    = 6;
    localparam int PAGE_IDX_W   = 9;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

    typedef enum logic [2:0] {
        PMTA_OP_READ_LOW   = 3'h0,
        PMTA_OP_READ_HIGH  = 3'h1,
        PMTA_OP_WRITE_LOW  = 3'h2,
        PMTA_OP_WRITE_HIGH = 3'h3,
        PMTA_OP_SET_PAGE   = 3'h4,
        PMTA_OP_PROG_WORD  = 3'h5,
        PMTA_OP_PROG_ROW   = 3'h6,
        PMTA_OP_ERASE_PAGE = 3'h7
    } pmta_op_t;

    // one table request from the core or the serial programming port
    typedef struct packed {
        pmta_op_t             op;
        logic                 byte_mode;
        logic [EA_W-1:0]      effective_address;
        logic [DATA_W-1:0]    wdata;
    } pmta_req_t;

    // one answer back to the requester
    typedef struct packed {
        logic                 valid;
        logic                 denied;
        logic [DATA_W-1:0]    rdata;
    } pmta_rsp_t;

endpackage

/* File: test/pmta_props.sv */
// checker: port relations of the table access block
// assumes one clock domain, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmta_props (
    input wire logic                [0:0] clk_sys,
    input wire logic                      rst,
    input wire logic                      exec_fetch,
    input wire logic               [22:0] program_counter,
    input wire logic                      req_valid,
    input wire pmta_pkg::pmta_req_t       req,
    input wire logic                      serial_prog_valid,
    input wire pmta_pkg::pmta_req_t       serial_prog_req,
    input wire logic               [23:0] flash_rdata,
    input wire logic                      flash_busy,
    input wire pmta_pkg::pmta_rsp_t       rsp,
    input wire pmta_pkg::pmta_rsp_t       serial_prog_rsp,
    input wire logic               [23:0] flash_addr,
    input wire logic               [23:0] flash_wdata,
    input wire logic                      flash_prog_word,
    input wire logic                      flash_prog_row,
    input wire logic                      flash_erase_page,
    input wire logic                [7:0] table_page_reg
);
    // ************************************************************
    // request tracking: a request is taken when nothing is in flight
    // ************************************************************
    logic       pend;
    logic       take;
    logic       ctake;
    logic [6:0] row_cnt;
    assign take  = (req_valid || serial_prog_valid) && (!pend || rsp.valid || serial_prog_rsp.valid);
    assign ctake = take && !serial_prog_valid;
    // in-flight flag, cleared by either answer
    always_ff @(posedge clk_sys) begin
        if (rst) pend <= 1'b0;
        else if (take) pend <= 1'b1;
        else if (rsp.valid || serial_prog_rsp.valid) pend <= 1'b0;
    end
    // length of the current run of row pulses
    always_ff @(posedge clk_sys) begin
        if (rst) row_cnt <= 7'h00;
        else row_cnt <= flash_prog_row ? row_cnt + 7'h01 : 7'h00;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> rsp == '0 && !flash_prog_row && table_page_reg == 8'h00)
        else $error("outputs not cleared by reset");
    a_low_word: assert property (ctake && req.op == pmta_pkg::PMTA_OP_READ_LOW && !req.byte_mode
        |=> rsp.valid && rsp.rdata == $past(flash_rdata[15:0])) else $error("low word read wrong");
    a_low_odd_byte: assert property (ctake && req.op == pmta_pkg::PMTA_OP_READ_LOW && req.byte_mode
        && req.effective_address[0] |=> rsp.rdata[7:0] == $past(flash_rdata[15:8])) else $error("odd byte wrong");
    a_high_word: assert property (ctake && req.op == pmta_pkg::PMTA_OP_READ_HIGH && !req.byte_mode
        |=> rsp.rdata == {8'h00, $past(flash_rdata[23:16])}) else $error("high word read wrong");
    a_target_form: assert property (ctake && req.op == pmta_pkg::PMTA_OP_READ_LOW
        |=> flash_addr == {$past(table_page_reg), $past(req.effective_address)}) else $error("target address wrong");
    a_page_load: assert property (ctake && req.op == pmta_pkg::PMTA_OP_SET_PAGE
        |=> table_page_reg == $past(req.wdata[7:0]) && rsp.valid) else $error("page not loaded");
    a_denied_empty: assert property (rsp.valid && rsp.denied |-> rsp.rdata == 16'h0000)
        else $error("denied answer carries data");
    a_serial_first: assert property (take && serial_prog_valid && req_valid
        |=> serial_prog_rsp.valid && !rsp.valid) else $error("serial request lost priority");
    a_row_length: assert property ($fell(flash_prog_row) |-> row_cnt == 7'd64) else $error("row run not 64");
    a_row_step: assert property (flash_prog_row && $past(flash_prog_row)
        |-> flash_addr == $past(flash_addr) + 24'h000002) else $error("row address step wrong");
    a_erase_pulse: assert property (ctake && req.op == pmta_pkg::PMTA_OP_ERASE_PAGE
        |=> flash_erase_page ##1 !flash_erase_page) else $error("erase pulse wrong");
    a_erase_align: assert property (flash_erase_page |-> flash_addr[9:0] == 10'h000)
        else $error("erase address not page aligned");
endmodule
bind pmta_table_access pmta_props u_props (.*);
`default_nettype wire

/* File: test/pmta_flash_model.sv */
// flash array model: word at the table target, busy after each op
// assumes page and effective address of the live request at its inputs
`timescale 1ns/1ps
`default_nettype none
module pmta_flash_model (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic  [7:0] page,
    input wire logic [15:0] ea,
    input wire logic        op_pulse,
    output logic     [23:0] rdata,
    output logic            busy
);
    logic [1:0] cnt;
    // word pattern per 24-bit address, no two neighbours alike
    assign rdata = {page ^ ea[15:8], ea ^ 16'h5a3c};
    assign busy  = cnt != 2'h0;
    // each op keeps the array busy three cycles, row pulses keep refreshing it
    always_ff @(posedge clk_sys) begin
        if (rst) cnt <= 2'h0;
        else if (op_pulse) cnt <= 2'h3;
        else if (busy) cnt <= cnt - 2'h1;
    end
endmodule
`default_nettype wire

/* File: test/program_memory_table_access_bench.sv */
// bench for the table access block, acting as core and serial port
// assumes the flash model on the array side
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_access_bench;
    logic clk_sys = 0, rst = 1, exec_fetch = 0, req_valid = 0, serial_prog_valid = 0;
    logic [22:0] program_counter = '0;
    pmta_pkg::pmta_req_t req = '0, serial_prog_req = '0;
    pmta_pkg::pmta_rsp_t rsp, serial_prog_rsp;
    logic [23:0] flash_rdata, flash_addr, flash_wdata, x, row_d[64];
    logic flash_busy, flash_prog_word, flash_prog_row, flash_erase_page;
    logic [7:0] table_page_reg;
    logic [15:0] rd, ea_live;
    int bad_count = 0, check_count = 0, cyc = 0, row_n = 0, word_n = 0, erase_n = 0;
    assign ea_live = serial_prog_valid ? serial_prog_req.effective_address : req.effective_address;
    pmta_table_access dut (.*);
    pmta_flash_model u_flash (.clk_sys(clk_sys), .rst(rst), .page(table_page_reg), .ea(ea_live),
        .op_pulse(flash_prog_word | flash_prog_row | flash_erase_page), .rdata(flash_rdata), .busy(flash_busy));
    // ************************************************************
    // clock, watchdog and op monitors
    // ************************************************************
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
        if (flash_prog_row && row_n < 64) row_d[row_n] = flash_wdata;
        row_n += flash_prog_row;
        word_n += flash_prog_word;
        erase_n += flash_erase_page;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (exp !== got) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [23:0] w(logic [7:0] p, logic [15:0] e);
        return {p ^ e[15:8], e ^ 16'h5a3c};
    endfunction
    // one core request raised for a single cycle, then wait for its answer
    task automatic req_do(pmta_pkg::pmta_op_t op, logic bm, logic [15:0] ea, logic [15:0] wd);
        int n = 0;
        req <= '{op, bm, ea, wd};
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.valid !== 1'b1 && n < 300);
        rd = rsp.rdata;
        chk("answer", 24'h1, rsp.valid);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reads();
        req_do(pmta_pkg::PMTA_OP_SET_PAGE, 0, 16'h0, 16'h0021);
        chk("page", 24'h21, table_page_reg);
        x = w(8'h21, 16'h1235);
        req_do(pmta_pkg::PMTA_OP_READ_LOW, 0, 16'h1235, 0);
        chk("low_word", x[15:0], rd);
        req_do(pmta_pkg::PMTA_OP_READ_LOW, 1, 16'h1235, 0);
        chk("low_odd", x[15:8], rd[7:0]);
        req_do(pmta_pkg::PMTA_OP_READ_HIGH, 1, 16'h1235, 0);
        chk("high_odd", 24'h0, rd[7:0]);
        x = w(8'h21, 16'h1234);
        req_do(pmta_pkg::PMTA_OP_READ_LOW, 1, 16'h1234, 0);
        chk("low_even", x[7:0], rd[7:0]);
        req_do(pmta_pkg::PMTA_OP_READ_HIGH, 0, 16'h1234, 0);
        chk("high_word", {8'h00, x[23:16]}, rd);
        req_do(pmta_pkg::PMTA_OP_READ_HIGH, 1, 16'h1234, 0);
        chk("high_even", x[23:16], rd[7:0]);
    endtask
    task automatic t_config();
        req_do(pmta_pkg::PMTA_OP_SET_PAGE, 0, 16'h0, 16'h0080);
        x = w(8'h80, 16'h0004);
        req_do(pmta_pkg::PMTA_OP_READ_LOW, 0, 16'h0004, 0);
        chk("cfg_denied", 24'h0, rsp.denied);
        chk("cfg_data", x[15:0], rd);
    endtask
    task automatic t_serial();
        x = w(8'h80, 16'h0021);
        serial_prog_req <= '{pmta_pkg::PMTA_OP_READ_LOW, 1'b0, 16'h0021, 16'h0};
        req <= '{pmta_pkg::PMTA_OP_READ_HIGH, 1'b0, 16'h0021, 16'h0};
        serial_prog_valid <= 1'b1;
        req_valid <= 1'b1;
        @(posedge clk_sys);
        serial_prog_valid <= 1'b0;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        chk("serial_first", 24'h1, serial_prog_rsp.valid);
        chk("serial_data", x[15:0], serial_prog_rsp.rdata);
        chk("serial_denied", 24'h0, serial_prog_rsp.denied);
        chk("core_held", 24'h0, rsp.valid);
        @(posedge clk_sys);
        chk("core_data", {8'h00, x[23:16]}, rsp.valid ? rsp.rdata : 16'hffff);
    endtask
    task automatic t_fetch();
        exec_fetch <= 1'b1;
        program_counter <= 23'h3abcde;
        repeat (3) @(posedge clk_sys);
        chk("fetch_addr", 24'h3abcde, flash_addr);
        exec_fetch <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic t_program();
        for (int i = 0; i < 64; i++) begin
            req_do(pmta_pkg::PMTA_OP_WRITE_LOW, 0, 16'(2 * i), 16'h1000 + 16'(i));
            req_do(pmta_pkg::PMTA_OP_WRITE_HIGH, 0, 16'(2 * i), 16'(i));
        end
        row_n = 0;
        req_do(pmta_pkg::PMTA_OP_PROG_ROW, 0, 16'h0, 0);
        chk("row_pulses", 24'd64, row_n);
        for (int i = 0; i < 64; i++) chk("row_word", {8'(i), 16'h1000 + 16'(i)}, row_d[i]);
        req_do(pmta_pkg::PMTA_OP_PROG_WORD, 0, 16'h0002, 0);
        chk("word_pulses", 24'd1, word_n);
        chk("word_data", {8'h01, 16'h1001}, flash_wdata);
        req_do(pmta_pkg::PMTA_OP_ERASE_PAGE, 0, 16'h0, 0);
        chk("erase_pulses", 24'd1, erase_n);
    endtask
    // main sequence: reset three cycles, then every scenario
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reads();
        t_config();
        t_serial();
        t_fetch();
        t_program();
        print_verdict();
    end
endmodule
`default_nettype wire
